/* File: rtl/mie_execute.sv */
// execute stage for a subset of the 8-bit core instruction set
// Operation
// - invert_mem complements the byte, writes it back, updates zero.
// - invert_to_wr puts complemented byte in work_reg, memory kept, zero updated.
// - bcd_adjust adds 06H/60H per nibble test and writes result to memory.
// - bcd_adjust changes only carry, set when the decimal sum reached 100.
// - decrement to memory or work_reg, both update zero.
// - increment to memory or work_reg, both update zero.
// - power-down stops execution and clock, keeps data, clears watchdog and prescaler.
// - power-down sets powerdown_flag, clears watchdog_expired_flag, nothing else.
// - jump_abs loads program counter, one dummy cycle, two cycles, no flags.
// - copy_op moves memory, immediate or work_reg bytes; no-op changes nothing.
// - disjunction with memory or immediate to work_reg or memory, zero updated.
// - leave_subroutine pops the pc; immediate form also loads work_reg.
// - leave_isr pops the pc and sets global_irq_enable, no flags.
// - a pending interrupt is serviced before returning to main program.
// - rotate left with bit 7 into bit 0, memory or work_reg, no flags.
// - rotate left through carry, only carry changes.
// - rotate right with bit 0 into bit 7, memory or work_reg, no flags.
// - rotate right through carry, only carry changes.
// - subtract with borrow updates wrap, zero, half carry and carry.
// - decrement-and-skip skips on zero result, memory or work_reg, no flags.
// - a skip inserts one dummy cycle, two cycles in total.
// - byte-set writes FFH, bit-set forces one bit, no flags.
// - skip takes one cycle when false, two when true.
module mie_execute
  import mie_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input mie_instr_t instr_i,
  input wire logic [PC_W-1:0] stack_top_i,
  input wire logic irq_pending_i,
  input wire logic wake_i,
  output logic instr_ready_o,
  output logic mem_we_o,
  output logic [7:0] mem_wdata_o,
  output logic [7:0] work_reg_o,
  output mie_flags_t flags_o,
  output logic global_irq_enable_o,
  output logic pc_load_o,
  output logic [PC_W-1:0] pc_value_o,
  output logic stack_pop_o,
  output logic irq_take_o,
  output logic skip_o,
  output logic clk_gate_off_o,
  output logic wdt_clear_o
);
  if (PC_W < 1 || PC_W > 16) begin : g_pc_w_check
    $error("mie_execute: PC_W must be 1..16");
  end

  typedef struct packed {
    mie_state_t st;
    logic mem_we;
    logic [7:0] mem_wdata;
    logic [7:0] work_reg;
    mie_flags_t flags;
    logic gie;
    logic pc_load;
    logic [PC_W-1:0] pc_value;
    logic stack_pop;
    logic irq_take;
    logic skip;
    logic wdt_clear;
    logic ready;
    logic gate_off;
  } mie_state_s_t;

  mie_state_s_t s_q;
  mie_state_s_t s_d;

  logic [7:0] m;
  logic [7:0] res;
  logic [8:0] diff;
  logic [4:0] diff_lo;
  logic [8:0] bcd;
  logic [7:0] bcd_add;
  logic signed_ovf;

  assign m = instr_i.mem_data;

  always_comb begin
    s_d = s_q;
    res = 8'h00;
    bcd_add = 8'h00;
    bcd = 9'h000;
    diff = 9'h000;
    diff_lo = 5'h00;
    signed_ovf = 1'b0;
    s_d.mem_we = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.stack_pop = 1'b0;
    s_d.irq_take = 1'b0;
    s_d.skip = 1'b0;
    s_d.wdt_clear = 1'b0;
    case (s_q.st)
      MIE_ST_HALTED: begin
        // clock stays gated until the wake logic outside restarts it
        if (wake_i) begin
          s_d.st = MIE_ST_RUN;
        end
      end
      MIE_ST_DUMMY: begin
        s_d.st = MIE_ST_RUN;
      end
      MIE_ST_RUN: begin
        if (instr_valid_i) begin
          case (instr_i.op)
            MIE_OP_NOP: begin
              res = s_q.work_reg;
            end
            MIE_OP_INVERT_MEM, MIE_OP_INVERT_TO_WR: begin
              res = ~m;
              s_d.flags.zero = (res == 8'h00);
              if (instr_i.op == MIE_OP_INVERT_MEM) begin
                s_d.mem_we = 1'b1;
                s_d.mem_wdata = res;
              end else begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_BCD_ADJUST: begin
              if (s_q.work_reg[3:0] > BCD_NIB_MAX || s_q.flags.half_carry) begin
                bcd_add = bcd_add | BCD_LO_ADD;
              end
              if (s_q.work_reg[7:4] > BCD_NIB_MAX || s_q.flags.carry) begin
                bcd_add = bcd_add | BCD_HI_ADD;
              end
              bcd = {1'b0, s_q.work_reg} + {1'b0, bcd_add};
              s_d.mem_we = 1'b1;
              s_d.mem_wdata = bcd[7:0];
              // carry is sticky so an earlier decimal overflow is not lost
              s_d.flags.carry = s_q.flags.carry | bcd[8];
            end
            MIE_OP_MINUS_ONE_MEM, MIE_OP_MINUS_ONE_TO_WR: begin
              res = m - 8'h01;
              s_d.flags.zero = (res == 8'h00);
              if (instr_i.op == MIE_OP_MINUS_ONE_MEM) begin
                s_d.mem_we = 1'b1;
                s_d.mem_wdata = res;
              end else begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_PLUS_ONE_MEM, MIE_OP_PLUS_ONE_TO_WR: begin
              res = m + 8'h01;
              s_d.flags.zero = (res == 8'h00);
              if (instr_i.op == MIE_OP_PLUS_ONE_MEM) begin
                s_d.mem_we = 1'b1;
                s_d.mem_wdata = res;
              end else begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_POWER_DOWN: begin
              s_d.st = MIE_ST_HALTED;
              s_d.wdt_clear = 1'b1;
              s_d.flags.powerdown = 1'b1;
              s_d.flags.wdt_expired = 1'b0;
            end
            MIE_OP_JUMP_ABS: begin
              s_d.pc_load = 1'b1;
              s_d.pc_value = instr_i.addr[PC_W-1:0];
              s_d.st = MIE_ST_DUMMY;
            end
            MIE_OP_COPY_MEM_TO_WR: begin
              s_d.work_reg = m;
            end
            MIE_OP_COPY_IMM_TO_WR: begin
              s_d.work_reg = instr_i.imm;
            end
            MIE_OP_COPY_WR_TO_MEM: begin
              s_d.mem_we = 1'b1;
              s_d.mem_wdata = s_q.work_reg;
            end
            MIE_OP_DISJ_MEM, MIE_OP_DISJ_IMM, MIE_OP_DISJ_TO_MEM: begin
              res = s_q.work_reg | ((instr_i.op == MIE_OP_DISJ_IMM) ? instr_i.imm : m);
              s_d.flags.zero = (res == 8'h00);
              if (instr_i.op == MIE_OP_DISJ_TO_MEM) begin
                s_d.mem_we = 1'b1;
                s_d.mem_wdata = res;
              end else begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_LEAVE_SUB, MIE_OP_LEAVE_SUB_IMM: begin
              s_d.stack_pop = 1'b1;
              s_d.pc_load = 1'b1;
              s_d.pc_value = stack_top_i;
              s_d.st = MIE_ST_DUMMY;
              if (instr_i.op == MIE_OP_LEAVE_SUB_IMM) begin
                s_d.work_reg = instr_i.imm;
              end
            end
            MIE_OP_LEAVE_ISR: begin
              s_d.stack_pop = 1'b1;
              s_d.pc_load = 1'b1;
              s_d.pc_value = stack_top_i;
              s_d.gie = 1'b1;
              s_d.st = MIE_ST_DUMMY;
              // pending interrupt is vectored before main code resumes
              s_d.irq_take = irq_pending_i;
            end
            MIE_OP_ROT_L_MEM, MIE_OP_ROT_L_TO_WR: begin
              res = {m[6:0], m[7]};
              s_d.mem_we = (instr_i.op == MIE_OP_ROT_L_MEM);
              s_d.mem_wdata = res;
              if (instr_i.op == MIE_OP_ROT_L_TO_WR) begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_ROT_LC_MEM, MIE_OP_ROT_LC_TO_WR: begin
              res = {m[6:0], s_q.flags.carry};
              s_d.flags.carry = m[7];
              s_d.mem_we = (instr_i.op == MIE_OP_ROT_LC_MEM);
              s_d.mem_wdata = res;
              if (instr_i.op == MIE_OP_ROT_LC_TO_WR) begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_ROT_R_MEM, MIE_OP_ROT_R_TO_WR: begin
              res = {m[0], m[7:1]};
              s_d.mem_we = (instr_i.op == MIE_OP_ROT_R_MEM);
              s_d.mem_wdata = res;
              if (instr_i.op == MIE_OP_ROT_R_TO_WR) begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_ROT_RC_MEM, MIE_OP_ROT_RC_TO_WR: begin
              res = {s_q.flags.carry, m[7:1]};
              s_d.flags.carry = m[0];
              s_d.mem_we = (instr_i.op == MIE_OP_ROT_RC_MEM);
              s_d.mem_wdata = res;
              if (instr_i.op == MIE_OP_ROT_RC_TO_WR) begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_SUB_BORROW, MIE_OP_SUB_BORROW_MEM: begin
              diff = {1'b0, s_q.work_reg} - {1'b0, m} - {8'h00, ~s_q.flags.carry};
              diff_lo = {1'b0, s_q.work_reg[3:0]} - {1'b0, m[3:0]} - {4'h0, ~s_q.flags.carry};
              res = diff[7:0];
              signed_ovf = (s_q.work_reg[7] != m[7]) && (res[7] != s_q.work_reg[7]);
              s_d.flags.carry = ~diff[8];
              s_d.flags.half_carry = ~diff_lo[4];
              s_d.flags.signed_wrap = signed_ovf;
              s_d.flags.zero = (res == 8'h00);
              s_d.mem_we = (instr_i.op == MIE_OP_SUB_BORROW_MEM);
              s_d.mem_wdata = res;
              if (instr_i.op == MIE_OP_SUB_BORROW) begin
                s_d.work_reg = res;
              end
            end
            MIE_OP_CNT_SKIP_MEM, MIE_OP_CNT_SKIP_TO_WR: begin
              res = m - 8'h01;
              s_d.mem_we = (instr_i.op == MIE_OP_CNT_SKIP_MEM);
              s_d.mem_wdata = res;
              if (instr_i.op == MIE_OP_CNT_SKIP_TO_WR) begin
                s_d.work_reg = res;
              end
              if (res == 8'h00) begin
                s_d.skip = 1'b1;
                s_d.st = MIE_ST_DUMMY;
              end
            end
            MIE_OP_SET_BYTE: begin
              s_d.mem_we = 1'b1;
              if (instr_i.bit_form) begin
                s_d.mem_wdata = m | (8'h01 << instr_i.bit_sel);
              end else begin
                s_d.mem_wdata = BYTE_ONES;
              end
            end
            default: begin
              s_d = s_q;
              s_d.mem_we = 1'b0;
              s_d.pc_load = 1'b0;
              s_d.stack_pop = 1'b0;
              s_d.irq_take = 1'b0;
              s_d.skip = 1'b0;
              s_d.wdt_clear = 1'b0;
            end
          endcase
        end
      end
      default: begin
        s_d.st = MIE_ST_RUN;
      end
    endcase
    // state decodes are registered so the outputs come straight from flops
    s_d.ready = (s_d.st == MIE_ST_RUN);
    s_d.gate_off = (s_d.st == MIE_ST_HALTED);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign instr_ready_o = s_q.ready;
  assign mem_we_o = s_q.mem_we;
  assign mem_wdata_o = s_q.mem_wdata;
  assign work_reg_o = s_q.work_reg;
  assign flags_o = s_q.flags;
  assign global_irq_enable_o = s_q.gie;
  assign pc_load_o = s_q.pc_load;
  assign pc_value_o = s_q.pc_value;
  assign stack_pop_o = s_q.stack_pop;
  assign irq_take_o = s_q.irq_take;
  assign skip_o = s_q.skip;
  assign clk_gate_off_o = s_q.gate_off;
  assign wdt_clear_o = s_q.wdt_clear;
endmodule : mie_execute

/* File: rtl/mie_pkg.sv */
// package for the instruction execute subset datapath
package mie_pkg;
  localparam int DATA_W = 8;
  localparam logic [7:0] BCD_LO_ADD = 8'h06;
  localparam logic [7:0] BCD_HI_ADD = 8'h60;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [3:0] BCD_NIB_MAX = 4'h9;
  localparam logic [7:0] WORK_REG_RST = 8'h00;
  localparam int PC_W_DEF = 11;

  typedef enum logic [4:0] {
    MIE_OP_NOP,
    MIE_OP_INVERT_MEM,
    MIE_OP_INVERT_TO_WR,
    MIE_OP_BCD_ADJUST,
    MIE_OP_MINUS_ONE_MEM,
    MIE_OP_MINUS_ONE_TO_WR,
    MIE_OP_PLUS_ONE_MEM,
    MIE_OP_PLUS_ONE_TO_WR,
    MIE_OP_POWER_DOWN,
    MIE_OP_JUMP_ABS,
    MIE_OP_COPY_MEM_TO_WR,
    MIE_OP_COPY_IMM_TO_WR,
    MIE_OP_COPY_WR_TO_MEM,
    MIE_OP_DISJ_MEM,
    MIE_OP_DISJ_IMM,
    MIE_OP_DISJ_TO_MEM,
    MIE_OP_LEAVE_SUB,
    MIE_OP_LEAVE_SUB_IMM,
    MIE_OP_LEAVE_ISR,
    MIE_OP_ROT_L_MEM,
    MIE_OP_ROT_L_TO_WR,
    MIE_OP_ROT_LC_MEM,
    MIE_OP_ROT_LC_TO_WR,
    MIE_OP_ROT_R_MEM,
    MIE_OP_ROT_R_TO_WR,
    MIE_OP_ROT_RC_MEM,
    MIE_OP_ROT_RC_TO_WR,
    MIE_OP_SUB_BORROW,
    MIE_OP_SUB_BORROW_MEM,
    MIE_OP_CNT_SKIP_MEM,
    MIE_OP_CNT_SKIP_TO_WR,
    MIE_OP_SET_BYTE
  } mie_op_t;

  // instruction as issued by the decoder
  typedef struct packed {
    mie_op_t op;
    logic bit_form;
    logic [2:0] bit_sel;
    logic [7:0] mem_data;
    logic [7:0] imm;
    logic [15:0] addr;
  } mie_instr_t;

  typedef struct packed {
    logic signed_wrap;
    logic zero;
    logic half_carry;
    logic carry;
    logic powerdown;
    logic wdt_expired;
  } mie_flags_t;

  typedef enum logic [1:0] {
    MIE_ST_RUN,
    MIE_ST_DUMMY,
    MIE_ST_HALTED
  } mie_state_t;
endpackage : mie_pkg

/* File: verification/mie_execute_checker.sv */
// concurrent checks on the execute stage ports
module mie_execute_checker
  import mie_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input mie_instr_t instr_i,
  input wire logic [PC_W-1:0] stack_top_i,
  input wire logic irq_pending_i,
  input wire logic wake_i,
  input wire logic instr_ready_o,
  input wire logic mem_we_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic [7:0] work_reg_o,
  input mie_flags_t flags_o,
  input wire logic global_irq_enable_o,
  input wire logic pc_load_o,
  input wire logic [PC_W-1:0] pc_value_o,
  input wire logic stack_pop_o,
  input wire logic irq_take_o,
  input wire logic skip_o,
  input wire logic clk_gate_off_o,
  input wire logic wdt_clear_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic tk;
  mie_op_t o;
  assign tk = instr_valid_i && instr_ready_o;
  assign o = instr_i.op;
  property p_jump;
    tk && o == MIE_OP_JUMP_ABS |=> pc_load_o && !instr_ready_o && pc_value_o == $past(instr_i.addr[PC_W-1:0])
      ##1 instr_ready_o && !pc_load_o;
  endproperty
  a_jump: assert property (p_jump) else $error("jump timing or target wrong");
  property p_inv;
    tk && o == MIE_OP_INVERT_MEM |=> mem_we_o && mem_wdata_o == ~$past(instr_i.mem_data);
  endproperty
  a_inv: assert property (p_inv) else $error("complement write wrong");
  property p_inv_wr;
    tk && o == MIE_OP_INVERT_TO_WR |=> !mem_we_o && work_reg_o == ~$past(instr_i.mem_data);
  endproperty
  a_inv_wr: assert property (p_inv_wr) else $error("complement to work_reg wrong");
  property p_zero;
    tk && o == MIE_OP_PLUS_ONE_MEM |=> flags_o.zero == (mem_wdata_o == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag disagrees with result");
  property p_bcd_flags;
    tk && o == MIE_OP_BCD_ADJUST |=> $stable({flags_o.signed_wrap, flags_o.zero, flags_o.half_carry})
      && !$fell(flags_o.carry);
  endproperty
  a_bcd_flags: assert property (p_bcd_flags) else $error("bcd adjust touched a flag");
  property p_halt;
    tk && o == MIE_OP_POWER_DOWN |=> flags_o.powerdown && !flags_o.wdt_expired && wdt_clear_o
      && clk_gate_off_o && $stable({flags_o.signed_wrap, flags_o.zero, flags_o.half_carry, flags_o.carry});
  endproperty
  a_halt: assert property (p_halt) else $error("power-down effects wrong");
  property p_gate;
    clk_gate_off_o && !wake_i |=> clk_gate_off_o && !instr_ready_o && !mem_we_o;
  endproperty
  a_gate: assert property (p_gate) else $error("halted state left without wake");
  property p_isr;
    tk && o == MIE_OP_LEAVE_ISR |=> global_irq_enable_o && stack_pop_o && pc_value_o == $past(stack_top_i)
      && (irq_take_o == $past(irq_pending_i));
  endproperty
  a_isr: assert property (p_isr) else $error("interrupt return wrong");
  property p_skip;
    tk && o == MIE_OP_CNT_SKIP_MEM && instr_i.mem_data == 8'h01 |=> skip_o && !instr_ready_o ##1 instr_ready_o;
  endproperty
  a_skip: assert property (p_skip) else $error("taken skip timing wrong");
  property p_noskip;
    tk && o == MIE_OP_CNT_SKIP_MEM && instr_i.mem_data != 8'h01 |=> !skip_o && instr_ready_o;
  endproperty
  a_noskip: assert property (p_noskip) else $error("untaken skip stalled");
  property p_rot;
    tk && (o == MIE_OP_ROT_L_MEM || o == MIE_OP_ROT_R_TO_WR) |=> flags_o == $past(flags_o);
  endproperty
  a_rot: assert property (p_rot) else $error("plain rotate changed flags");
  property p_set;
    tk && o == MIE_OP_SET_BYTE && !instr_i.bit_form |=> mem_we_o && mem_wdata_o == BYTE_ONES;
  endproperty
  a_set: assert property (p_set) else $error("byte set wrong");
  c_skip: cover property (skip_o);
  c_irq: cover property (irq_take_o);
  c_halt: cover property (clk_gate_off_o);
endmodule : mie_execute_checker
bind mie_execute mie_execute_checker #(.PC_W(PC_W)) chk_u (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
  .stack_top_i(stack_top_i), .irq_pending_i(irq_pending_i), .wake_i(wake_i), .instr_ready_o(instr_ready_o),
  .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .work_reg_o(work_reg_o), .flags_o(flags_o),
  .global_irq_enable_o(global_irq_enable_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
  .stack_pop_o(stack_pop_o), .irq_take_o(irq_take_o), .skip_o(skip_o), .clk_gate_off_o(clk_gate_off_o),
  .wdt_clear_o(wdt_clear_o));

/* File: verification/mie_execute_tb_top.sv */
// self-checking bench for the execute stage
module mie_execute_tb_top import mie_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PC_W = 11;
  logic sys_clk_i, rst_n_i, instr_valid_i, irq_pending_i, wake_i, instr_ready_o, mem_we_o;
  logic global_irq_enable_o, pc_load_o, stack_pop_o, irq_take_o, skip_o, clk_gate_off_o, wdt_clear_o;
  logic [PC_W-1:0] stack_top_i, pc_value_o;
  logic [7:0] mem_wdata_o, work_reg_o, rd, imm;
  mie_instr_t instr_i;
  mie_flags_t flags_o, f;
  mie_op_t op;
  logic bform;
  logic [2:0] bsel;
  logic [15:0] addr;
  int miscompares = 0;
  int total_checks = 0;
  assign instr_i = {op, bform, bsel, rd, imm, addr};
  mie_execute #(.PC_W(PC_W)) dut_u (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
    .stack_top_i(stack_top_i), .irq_pending_i(irq_pending_i), .wake_i(wake_i), .instr_ready_o(instr_ready_o),
    .mem_we_o(mem_we_o), .mem_wdata_o(mem_wdata_o), .work_reg_o(work_reg_o), .flags_o(flags_o),
    .global_irq_enable_o(global_irq_enable_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
    .stack_pop_o(stack_pop_o), .irq_take_o(irq_take_o), .skip_o(skip_o), .clk_gate_off_o(clk_gate_off_o),
    .wdt_clear_o(wdt_clear_o));
  mie_mem_model mem_u (.sys_clk_i(sys_clk_i), .take_i(instr_valid_i && instr_ready_o), .addr_i(addr[3:0]),
    .we_i(mem_we_o), .wdata_i(mem_wdata_o), .rdata_o(rd));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic end_sim;
    if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] g, e);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic issue(input mie_op_t o, input logic [3:0] a, input logic [7:0] x);
    @(negedge sys_clk_i);
    op = o;
    addr = {12'h000, a};
    imm = x;
    instr_valid_i = 1'b1;
    @(negedge sys_clk_i);
    instr_valid_i = 1'b0;
  endtask : issue
  // memory is loaded through the core itself, so one also exercises the moves
  task automatic one(input mie_op_t o, input logic [7:0] m, w, x, e, input logic to_mem);
    issue(MIE_OP_COPY_IMM_TO_WR, 4'h1, m);
    issue(MIE_OP_COPY_WR_TO_MEM, 4'h1, 8'h00);
    chk({mem_we_o, mem_wdata_o}, {1'b1, m});
    issue(MIE_OP_COPY_IMM_TO_WR, 4'h1, w);
    issue(o, 4'h1, x);
    chk({mem_we_o, to_mem ? mem_wdata_o : work_reg_o}, {to_mem, e});
  endtask : one
  task automatic t_logic;
    one(MIE_OP_INVERT_MEM, 8'h5A, 8'h00, 8'h00, 8'hA5, 1);
    one(MIE_OP_INVERT_TO_WR, 8'hFF, 8'h33, 8'h00, 8'h00, 0);
    chk(flags_o.zero, 1'b1);
    one(MIE_OP_PLUS_ONE_MEM, 8'hFF, 8'h00, 8'h00, 8'h00, 1);
    one(MIE_OP_PLUS_ONE_TO_WR, 8'h7F, 8'h00, 8'h00, 8'h80, 0);
    chk(flags_o.zero, 1'b0);
    one(MIE_OP_MINUS_ONE_MEM, 8'h00, 8'h00, 8'h00, 8'hFF, 1);
    one(MIE_OP_MINUS_ONE_TO_WR, 8'h01, 8'h55, 8'h00, 8'h00, 0);
    chk(flags_o.zero, 1'b1);
    one(MIE_OP_DISJ_MEM, 8'h5A, 8'h0F, 8'h00, 8'h5F, 0);
    one(MIE_OP_DISJ_IMM, 8'h00, 8'h0F, 8'hF0, 8'hFF, 0);
    one(MIE_OP_DISJ_TO_MEM, 8'h00, 8'h00, 8'hFF, 8'h00, 1);
    chk(flags_o.zero, 1'b1);
    one(MIE_OP_SET_BYTE, 8'h12, 8'h00, 8'h00, 8'hFF, 1);
    one(MIE_OP_COPY_MEM_TO_WR, 8'h3C, 8'h00, 8'h00, 8'h3C, 0);
    one(MIE_OP_NOP, 8'h00, 8'h99, 8'h00, 8'h99, 0);
    bform = 1'b1;
    bsel = 3'd3;
    issue(MIE_OP_SET_BYTE, 4'h1, 8'h00);
    chk({mem_we_o, mem_wdata_o}, 9'h108);
    bform = 1'b0;
  endtask : t_logic
  task automatic t_bcd;
    one(MIE_OP_BCD_ADJUST, 8'h00, 8'hAA, 8'h00, 8'h10, 1);
    chk(flags_o.carry, 1'b1);
    one(MIE_OP_BCD_ADJUST, 8'h00, 8'h45, 8'h00, 8'hA5, 1);
  endtask : t_bcd
  task automatic t_rot;
    one(MIE_OP_ROT_L_MEM, 8'h81, 8'h00, 8'h00, 8'h03, 1);
    one(MIE_OP_ROT_L_TO_WR, 8'h81, 8'h00, 8'h00, 8'h03, 0);
    one(MIE_OP_ROT_R_MEM, 8'h81, 8'h00, 8'h00, 8'hC0, 1);
    one(MIE_OP_ROT_R_TO_WR, 8'h81, 8'h00, 8'h00, 8'hC0, 0);
    one(MIE_OP_ROT_LC_MEM, 8'h01, 8'h00, 8'h00, 8'h03, 1);
    chk(flags_o.carry, 1'b0);
    one(MIE_OP_ROT_RC_TO_WR, 8'h01, 8'h00, 8'h00, 8'h00, 0);
    chk(flags_o.carry, 1'b1);
    one(MIE_OP_ROT_LC_TO_WR, 8'h80, 8'h00, 8'h00, 8'h01, 0);
    one(MIE_OP_ROT_RC_MEM, 8'h00, 8'h00, 8'h00, 8'h80, 1);
    chk(flags_o.carry, 1'b0);
  endtask : t_rot
  task automatic t_sbc;
    one(MIE_OP_SUB_BORROW, 8'h01, 8'h05, 8'h00, 8'h03, 0);
    chk({flags_o.signed_wrap, flags_o.zero, flags_o.half_carry, flags_o.carry}, 4'b0011);
    one(MIE_OP_SUB_BORROW_MEM, 8'h01, 8'h80, 8'h00, 8'h7F, 1);
    chk({flags_o.signed_wrap, flags_o.zero, flags_o.half_carry, flags_o.carry}, 4'b1001);
    one(MIE_OP_SUB_BORROW, 8'h01, 8'h00, 8'h00, 8'hFF, 0);
    chk({flags_o.signed_wrap, flags_o.zero, flags_o.half_carry, flags_o.carry}, 4'b0000);
    one(MIE_OP_SUB_BORROW_MEM, 8'h00, 8'h01, 8'h00, 8'h00, 1);
    chk({flags_o.signed_wrap, flags_o.zero, flags_o.half_carry, flags_o.carry}, 4'b0111);
  endtask : t_sbc
  task automatic t_skip;
    f = flags_o;
    one(MIE_OP_CNT_SKIP_MEM, 8'h01, 8'h00, 8'h00, 8'h00, 1);
    chk({skip_o, instr_ready_o}, 2'b10);
    one(MIE_OP_CNT_SKIP_MEM, 8'h05, 8'h00, 8'h00, 8'h04, 1);
    chk({skip_o, instr_ready_o}, 2'b01);
    one(MIE_OP_CNT_SKIP_TO_WR, 8'h01, 8'h77, 8'h00, 8'h00, 0);
    chk({skip_o, flags_o}, {1'b1, f});
  endtask : t_skip
  task automatic t_flow;
    issue(MIE_OP_JUMP_ABS, 4'h5, 8'h00);
    chk({pc_load_o, instr_ready_o, pc_value_o}, {2'b10, 11'h005});
    stack_top_i = 11'h2AA;
    issue(MIE_OP_LEAVE_SUB, 4'h0, 8'h00);
    chk({pc_load_o, stack_pop_o, pc_value_o}, {2'b11, 11'h2AA});
    issue(MIE_OP_LEAVE_SUB_IMM, 4'h0, 8'h77);
    chk(work_reg_o, 8'h77);
    irq_pending_i = 1'b1;
    issue(MIE_OP_LEAVE_ISR, 4'h0, 8'h00);
    chk({global_irq_enable_o, irq_take_o, stack_pop_o}, 3'b111);
    irq_pending_i = 1'b0;
  endtask : t_flow
  task automatic t_halt;
    issue(MIE_OP_POWER_DOWN, 4'h0, 8'h00);
    chk({clk_gate_off_o, wdt_clear_o, flags_o.powerdown, flags_o.wdt_expired, instr_ready_o}, 5'b11100);
    issue(MIE_OP_COPY_IMM_TO_WR, 4'h0, 8'h11);
    wake_i = 1'b1;
    @(negedge sys_clk_i);
    wake_i = 1'b0;
    for (int i = 0; i < 8 && instr_ready_o !== 1'b1; i++) @(negedge sys_clk_i);
    chk({clk_gate_off_o, instr_ready_o, work_reg_o}, {2'b01, 8'h77});
  endtask : t_halt
  initial begin
    #50us;
    miscompares++;
    end_sim;
  end
  initial begin
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    irq_pending_i = 1'b0;
    wake_i = 1'b0;
    stack_top_i = '0;
    op = MIE_OP_NOP;
    bform = 1'b0;
    bsel = 3'd0;
    imm = 8'h00;
    addr = 16'h0000;
    repeat (5) @(negedge sys_clk_i);
    chk({instr_ready_o, work_reg_o, flags_o}, {1'b1, 8'h00, 6'h00});
    rst_n_i = 1'b1;
    t_logic;
    t_bcd;
    t_rot;
    t_sbc;
    t_skip;
    t_flow;
    t_halt;
    end_sim;
  end
endmodule : mie_execute_tb_top

/* File: verification/mie_mem_model.sv */
// data memory model on the far side of the execute stage
module mie_mem_model (
  input wire logic sys_clk_i,
  input wire logic take_i,
  input wire logic [3:0] addr_i,
  input wire logic we_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem_q [16];
  logic [3:0] wa_q;
  assign rdata_o = mem_q[addr_i];
  // write strobe trails the take by a cycle, so hold the address
  always_ff @(posedge sys_clk_i) begin
    if (take_i) wa_q <= addr_i;
    if (we_i) mem_q[wa_q] <= wdata_i;
  end
endmodule : mie_mem_model
